// [logic/sdbg_cfg.svh]
// timing constants for the single-wire debug link host controller
// assumes a 40 MHz host clock and a target serial clock of host clock / SDBG_TGT_DIV
// ============================================================
`ifndef SDBG_CFG_SVH
`define SDBG_CFG_SVH

// ============================================================
// link timing, in target clock cycles except SDBG_TGT_DIV, in host clocks
`define SDBG_TGT_DIV 4
`define SDBG_BIT_TICKS 16
`define SDBG_ONE_LOW 4
`define SDBG_ONE_MAX 8
`define SDBG_ZERO_LOW 13
`define SDBG_RX_LOW 2
`define SDBG_DEV_SPEEDUP 7
`define SDBG_RX_SAMPLE 10
`define SDBG_SYNC_MIN 128
`define SDBG_SYNC_LOW 130
`define SDBG_TIMEOUT 512

`endif

// [logic/sdbg_pkg.sv]
// types shared by the debug link host controller
// assumes sdbg_cfg.svh holds all numeric timing
package sdbg_pkg;

    // ============================================================
    // operations the user side may request
    typedef enum logic [1:0] {
        SDBG_OP_TX = 2'h0,
        SDBG_OP_RX = 2'h1,
        SDBG_OP_WAIT = 2'h2,
        SDBG_OP_ABORT = 2'h3
    } sdbg_op_t;

    typedef struct packed {
        sdbg_op_t op;
        logic [15:0] data;
        logic [4:0] nbits;
        logic odd;
    } sdbg_req_t;

    typedef struct packed {
        logic [15:0] word;
        logic [7:0] sel_byte;
    } sdbg_rsp_t;

    typedef enum logic [2:0] {
        SDBG_IDLE = 3'h0,
        SDBG_TX = 3'h1,
        SDBG_RX = 3'h2,
        SDBG_WAIT = 3'h3,
        SDBG_ABORT = 3'h4
    } sdbg_state_t;

endpackage

// [logic/sdbg_host.sv]
// host controller for a single-wire background debug link
// assumes an external pull-up on the wire and a pad that merges oe/out/in
`timescale 1ns/1ps
`default_nettype none
`include "sdbg_cfg.svh"

module sdbg_host
    import sdbg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic req_valid,
    output logic req_ready,
    input wire sdbg_req_t req,
    output logic rsp_valid,
    output sdbg_rsp_t rsp,
    input wire logic wire_in,
    output logic wire_out,
    output logic wire_oe
);

    // ============================================================
    // state
    sdbg_state_t state, next_state;
    logic [1:0] dcnt, next_dcnt;
    logic [7:0] tcnt, next_tcnt;
    logic [4:0] bcnt, next_bcnt;
    logic [15:0] shift, next_shift;
    logic odd, next_odd;
    logic seen_low, next_seen_low;
    logic [1:0] sync, next_sync;
    logic drv_oe, next_drv_oe;
    logic drv_hi, next_drv_hi;
    logic rsp_v, next_rsp_v;
    sdbg_rsp_t rsp_q, next_rsp;
    logic tick;
    logic wire_s;
    logic take;

    assign wire_s = sync[1];
    // divider: one target clock is SDBG_TGT_DIV host clocks
    assign tick = (dcnt == 2'(`SDBG_TGT_DIV - 1));
    // only an abort may cut into a pending acknowledge wait
    assign req_ready = (state == SDBG_IDLE) || ((state == SDBG_WAIT) && (req.op == SDBG_OP_ABORT));
    assign take = req_valid && req_ready;
    assign wire_oe = drv_oe;
    assign wire_out = drv_hi;
    assign rsp_valid = rsp_v;
    assign rsp = rsp_q;

    // ============================================================
    // next-state and pin drive
    always_comb
    begin
        next_state = state;
        next_dcnt = tick ? 2'h0 : dcnt + 2'h1;
        next_tcnt = tcnt;
        next_bcnt = bcnt;
        next_shift = shift;
        next_odd = odd;
        next_seen_low = seen_low;
        next_sync = {sync[0], wire_in};
        next_drv_oe = 1'b0;
        next_drv_hi = 1'b0;
        next_rsp_v = 1'b0;
        next_rsp = rsp_q;
        case (state)
            SDBG_IDLE, SDBG_WAIT:
            begin
                // no drive while the target may own the wire
                if (state == SDBG_WAIT)
                begin
                    if (!wire_s)
                        next_seen_low = 1'b1;
                    // pulse seen and released: done, however late, no fixed delay
                    if (seen_low && wire_s)
                    begin
                        next_state = SDBG_IDLE;
                        next_rsp_v = 1'b1; // result fetch may follow
                    end
                end
                if (take)
                begin
                    next_dcnt = 2'h0;
                    next_tcnt = 8'h00;
                    next_seen_low = 1'b0;
                    next_bcnt = req.nbits;
                    next_odd = req.odd;
                    next_rsp_v = 1'b0;
                    // data arrives right aligned, shifted out msb first
                    next_shift = req.data << (5'h10 - req.nbits);
                    case (req.op)
                        SDBG_OP_TX: next_state = SDBG_TX;
                        SDBG_OP_RX: next_state = SDBG_RX;
                        SDBG_OP_WAIT: next_state = SDBG_WAIT;
                        default: next_state = SDBG_ABORT;
                    endcase
                end
            end
            SDBG_TX:
            begin
                // one released early, zero held past the sample point
                if (tcnt < (shift[15] ? 8'(`SDBG_ONE_LOW) : 8'(`SDBG_ZERO_LOW)))
                    next_drv_oe = 1'b1;
                else if (tcnt == (shift[15] ? 8'(`SDBG_ONE_LOW) : 8'(`SDBG_ZERO_LOW)))
                begin
                    next_drv_oe = 1'b1; // speedup, one target clock
                    next_drv_hi = 1'b1;
                end
                if (tick)
                begin
                    next_tcnt = tcnt + 8'h01;
                    if (tcnt == 8'(`SDBG_BIT_TICKS - 1))
                    begin
                        next_tcnt = 8'h00;
                        next_shift = {shift[14:0], 1'b0};
                        next_bcnt = bcnt - 5'h01;
                        if (bcnt == 5'h01)
                        begin
                            next_state = SDBG_IDLE;
                            next_rsp_v = 1'b1;
                        end
                    end
                end
            end
            SDBG_RX:
            begin
                // short low, released well before the target speedup
                if (tcnt < 8'(`SDBG_RX_LOW))
                    next_drv_oe = 1'b1;
                if (tick)
                begin
                    next_tcnt = tcnt + 8'h01;
                    if (tcnt == 8'(`SDBG_RX_SAMPLE))
                        next_shift = {shift[14:0], wire_s};
                    if (tcnt == 8'(`SDBG_BIT_TICKS - 1))
                    begin
                        next_tcnt = 8'h00;
                        next_bcnt = bcnt - 5'h01;
                        if (bcnt == 5'h01)
                        begin
                            next_state = SDBG_IDLE;
                            next_rsp_v = 1'b1;
                            next_rsp.word = shift;
                            // byte reads: parity picks the valid half
                            next_rsp.sel_byte = odd ? shift[7:0] : shift[15:8];
                        end
                    end
                end
            end
            SDBG_ABORT:
            begin
                // long low then one driven high clock
                next_drv_oe = 1'b1;
                next_drv_hi = (tcnt == 8'(`SDBG_SYNC_LOW));
                if (tick)
                begin
                    next_tcnt = tcnt + 8'h01;
                    if (tcnt == 8'(`SDBG_SYNC_LOW))
                    begin
                        next_state = SDBG_IDLE;
                        next_rsp_v = 1'b1;
                    end
                end
            end
            default:
            begin
                next_state = SDBG_IDLE;
            end
        endcase
    end

    // registers only
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state <= SDBG_IDLE;
            dcnt <= 2'h0;
            tcnt <= 8'h00;
            bcnt <= 5'h00;
            shift <= 16'h0000;
            odd <= 1'b0;
            seen_low <= 1'b0;
            sync <= 2'h3; // idle wire reads high
            drv_oe <= 1'b0;
            drv_hi <= 1'b0;
            rsp_v <= 1'b0;
            rsp_q <= '0;
        end
        else
        begin
            state <= next_state;
            dcnt <= next_dcnt;
            tcnt <= next_tcnt;
            bcnt <= next_bcnt;
            shift <= next_shift;
            odd <= next_odd;
            seen_low <= next_seen_low;
            sync <= next_sync;
            drv_oe <= next_drv_oe;
            drv_hi <= next_drv_hi;
            rsp_v <= next_rsp_v;
            rsp_q <= next_rsp;
        end
    end

    // ============================================================
    // checks; helper counters measure driven lows and bit spacing
    localparam int C_DIV = `SDBG_TGT_DIV;
    logic drv_low;
    logic drv_low_q;
    logic in_frame;
    logic [9:0] lowrun;
    logic [9:0] gap;
    assign drv_low = drv_oe && !drv_hi;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            drv_low_q <= 1'b0;
            in_frame <= 1'b0;
            lowrun <= 10'h000;
            gap <= 10'h000;
        end
        else
        begin
            drv_low_q <= drv_low;
            lowrun <= drv_low ? lowrun + 10'h001 : 10'h000;
            gap <= (drv_low && !drv_low_q) ? 10'h000 : gap + 10'h001;
            if (state == SDBG_IDLE)
                in_frame <= 1'b0;
            else if (drv_low && !drv_low_q)
                in_frame <= 1'b1;
        end
    end

    property p_bit_period;
        @(posedge clk) disable iff (!rst_b)
        (drv_low && !drv_low_q && in_frame && (state == SDBG_TX || state == SDBG_RX))
            |-> (gap == 10'(`SDBG_BIT_TICKS * `SDBG_TGT_DIV - 1));
    endproperty
    a_bit_period: assert property (p_bit_period) else $error("bit period wrong");

    property p_bit_start;
        @(posedge clk) disable iff (!rst_b)
        ((state == SDBG_TX || state == SDBG_RX) && tcnt == 8'h01) |-> drv_low;
    endproperty
    a_bit_start: assert property (p_bit_start) else $error("bit not opened low");

    property p_tx_low;
        @(posedge clk) disable iff (!rst_b)
        (!drv_low && drv_low_q && state == SDBG_TX)
            |-> (lowrun == 10'(`SDBG_ONE_LOW * `SDBG_TGT_DIV) || lowrun == 10'(`SDBG_ZERO_LOW * `SDBG_TGT_DIV));
    endproperty
    a_tx_low: assert property (p_tx_low) else $error("tx low length wrong");

    property p_speedup;
        @(posedge clk) disable iff (!rst_b)
        $rose(drv_oe && drv_hi) |-> ##C_DIV !drv_oe;
    endproperty
    a_speedup: assert property (p_speedup) else $error("speedup length wrong");

    property p_rx_low;
        @(posedge clk) disable iff (!rst_b)
        (!drv_low && drv_low_q && state == SDBG_RX) |-> (lowrun == 10'(`SDBG_RX_LOW * `SDBG_TGT_DIV));
    endproperty
    a_rx_low: assert property (p_rx_low) else $error("rx low length wrong");

    property p_sync_low;
        @(posedge clk) disable iff (!rst_b)
        (!drv_low && drv_low_q && state == SDBG_ABORT)
            |-> (lowrun == 10'(`SDBG_SYNC_LOW * `SDBG_TGT_DIV)) && (lowrun >= 10'(`SDBG_SYNC_MIN * `SDBG_TGT_DIV));
    endproperty
    a_sync_low: assert property (p_sync_low) else $error("abort low too short");

    property p_no_drive_wait;
        @(posedge clk) disable iff (!rst_b)
        (state == SDBG_WAIT) |-> !drv_oe;
    endproperty
    a_no_drive_wait: assert property (p_no_drive_wait) else $error("drive during wait");

    property p_wait_abort;
        @(posedge clk) disable iff (!rst_b)
        (state == SDBG_WAIT && req_valid && req.op == SDBG_OP_ABORT) |=> (state == SDBG_ABORT) ##1 drv_low;
    endproperty
    a_wait_abort: assert property (p_wait_abort) else $error("abort not taken");

    property p_ack_done;
        @(posedge clk) disable iff (!rst_b)
        (state == SDBG_WAIT && seen_low && wire_s && !take) |=> rsp_valid && (state == SDBG_IDLE);
    endproperty
    a_ack_done: assert property (p_ack_done) else $error("ack end missed");

    property p_byte_sel;
        @(posedge clk) disable iff (!rst_b)
        (rsp_valid && $past(state) == SDBG_RX) |-> (rsp.sel_byte == (odd ? rsp.word[7:0] : rsp.word[15:8]));
    endproperty
    a_byte_sel: assert property (p_byte_sel) else $error("byte select wrong");

    c_tx: cover property (@(posedge clk) disable iff (!rst_b) state == SDBG_TX ##1 state == SDBG_IDLE);
    c_rx: cover property (@(posedge clk) disable iff (!rst_b) state == SDBG_RX ##1 rsp_valid);
    c_ack: cover property (@(posedge clk) disable iff (!rst_b) state == SDBG_WAIT ##1 rsp_valid);
    c_abort: cover property (@(posedge clk) disable iff (!rst_b) state == SDBG_WAIT ##1 state == SDBG_ABORT);

endmodule // sdbg_host

`default_nettype wire

// [tb/sdbg_target.sv]
// device-side model of the single-wire debug link, one target clock = SDBG_TGT_DIV clk
// assumes the bench resolves the wire (pull-up when nobody drives) and feeds it back
`timescale 1ns/1ps
`default_nettype none
`include "sdbg_cfg.svh"

module sdbg_target
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wire_lvl,
    input wire logic tx_mode,
    input wire logic [15:0] tx_word,
    input wire logic ack_go,
    output logic drv_oe,
    output logic drv_out,
    output logic [15:0] rx_word,
    output logic mode_sel
);
    logic [15:0] sh;
    logic b;
    int since;

    // ============================================================
    // mode pin is only looked at while reset is held
    always @(posedge clk)
        if (!rst_b)
            mode_sel <= wire_lvl;

    // all delays counted in target clocks
    task automatic tick(input int n);
        repeat (n * `SDBG_TGT_DIV) @(posedge clk);
        since += n;
    endtask

    // ============================================================
    // bit engine, restarted at every perceived host falling edge
    initial
    begin
        drv_oe = 1'b0;
        drv_out = 1'b0;
        rx_word = 16'h0000;
        sh = 16'h0000;
        since = 0;
        wait (rst_b);
        forever
        begin
            tick(1);
            if (!tx_mode)
                sh = tx_word;
            if (since == `SDBG_TIMEOUT)
                rx_word = 16'h0000; // stale partial frame dropped
            // ack only for executed commands, never before end of bit plus 32
            if (ack_go && since >= `SDBG_BIT_TICKS + 32)
            begin
                drv_oe <= 1'b1;
                drv_out <= 1'b0;
                tick(16);
                drv_out <= 1'b1;
                tick(1);
                drv_oe <= 1'b0;
                wait (!ack_go);
            end
            else if (!wire_lvl)
            begin
                since = 0; // perceived start, within one target clock
                if (tx_mode && sh[15])
                begin
                    tick(`SDBG_DEV_SPEEDUP);
                    drv_oe <= 1'b1;
                    drv_out <= 1'b1;
                    tick(1);
                    drv_oe <= 1'b0;
                end
                else if (tx_mode)
                begin
                    tick(1);
                    drv_oe <= 1'b1;
                    drv_out <= 1'b0;
                    tick(`SDBG_ZERO_LOW - 1);
                    drv_out <= 1'b1;
                    tick(1);
                    drv_oe <= 1'b0;
                end
                else
                begin
                    tick(`SDBG_RX_SAMPLE);
                    b = wire_lvl;
                    while (!wire_lvl)
                        tick(1);
                    // a long low is a sync request, not data
                    if (since < `SDBG_SYNC_MIN)
                        rx_word = {rx_word[14:0], b};
                end
                sh = sh << 1;
            end
        end
    end
endmodule // sdbg_target
`default_nettype wire

// [tb/sdbg_host_tb.sv]
// self-checking bench for the debug link host controller
// assumes sdbg_target stands at the far end of the wire
`timescale 1ns/1ps
`default_nettype none
`include "sdbg_cfg.svh"

module sdbg_host_tb
    import sdbg_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    sdbg_req_t req = '0;
    logic req_ready, rsp_valid, wire_out, wire_oe, t_oe, t_out, mode_sel, wire_lvl;
    sdbg_rsp_t rsp;
    logic tx_mode = 1'b0;
    logic ack_go = 1'b0; // acknowledge off after reset
    logic [15:0] tx_word = 16'h0000;
    logic [15:0] rx_word;
    int miscompares = 0;
    int compares = 0;
    int cyc = 0;
    int lowcnt = 0;
    int lows[$];

    always #12.5 clk = ~clk;
    // pull-up wins whenever nobody drives
    assign wire_lvl = wire_oe ? wire_out : (t_oe ? t_out : 1'b1);

    sdbg_host uut (.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .rsp_valid(rsp_valid), .rsp(rsp), .wire_in(wire_lvl), .wire_out(wire_out), .wire_oe(wire_oe));
    sdbg_target tgt (.clk(clk), .rst_b(rst_b), .wire_lvl(wire_lvl), .tx_mode(tx_mode), .tx_word(tx_word),
        .ack_go(ack_go), .drv_oe(t_oe), .drv_out(t_out), .rx_word(rx_word), .mode_sel(mode_sel));

    // ============================================================
    // monitors: low lengths, drive conflicts, hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (!wire_lvl)
            lowcnt++;
        else if (lowcnt != 0)
        begin
            lows.push_back(lowcnt);
            lowcnt = 0;
        end
        if (wire_oe && t_oe && wire_out !== t_out)
            check(16'(wire_out), 16'(t_out));
        if (cyc == 30000)
        begin
            miscompares++;
            results();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // bounded wait for the one-cycle completion pulse
    task automatic wait_rsp();
        int k;
        k = 0;
        do
        begin
            @(negedge clk);
            k++;
        end
        while (!rsp_valid && k < 5000);
        check(16'(rsp_valid), 16'h0001);
    endtask

    // offer a request and hold it until taken
    task automatic op(input sdbg_op_t o, input logic [15:0] d, input logic [4:0] n, input logic odd, input bit w);
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{o, d, n, odd};
        do
            @(negedge clk);
        while (!req_ready);
        @(posedge clk);
        req_valid <= 1'b0;
        if (w)
            wait_rsp();
    endtask

    // ============================================================
    // scenarios
    task automatic t_tx(input logic [15:0] d, input logic [4:0] n);
        logic [15:0] m;
        m = 16'hFFFF >> (16 - n);
        lows.delete();
        op(SDBG_OP_TX, d, n, 1'b0, 1'b1);
        check(rx_word & m, d & m);
        for (int i = 0; i < n; i++)
            check(16'(lows[i]), d[n - 1 - i] ? 16'h0010 : 16'h0034);
        $display("t_tx done");
    endtask

    task automatic t_rx(input logic [15:0] w, input logic odd);
        tx_word <= w;
        repeat (8) @(posedge clk);
        tx_mode <= 1'b1;
        op(SDBG_OP_RX, 16'h0000, 5'h10, odd, 1'b1);
        check(rsp.word, w);
        check(16'(rsp.sel_byte), 16'(odd ? w[7:0] : w[15:8]));
        tx_mode <= 1'b0;
        $display("t_rx done");
    endtask

    task automatic t_ack();
        int t0;
        op(SDBG_OP_TX, 16'h005B, 5'h08, 1'b0, 1'b1);
        t0 = cyc;
        ack_go <= 1'b1;
        op(SDBG_OP_WAIT, 16'h0000, 5'h01, 1'b0, 1'b0);
        // one edge between the release and the next offer
        @(posedge clk);
        req_valid <= 1'b1;
        req.op <= SDBG_OP_TX;
        @(negedge clk);
        check(16'(req_ready), 16'h0000);
        @(posedge clk);
        req_valid <= 1'b0;
        wait_rsp();
        check(16'(cyc - t0 >= 192), 16'h0001);
        check(16'(lows[$]), 16'h0040);
        ack_go <= 1'b0;
        $display("t_ack done");
    endtask

    task automatic t_abort();
        op(SDBG_OP_TX, 16'h00C4, 5'h08, 1'b0, 1'b1);
        op(SDBG_OP_WAIT, 16'h0000, 5'h01, 1'b0, 1'b0); // no ack will come
        repeat (400) @(posedge clk);
        lows.delete();
        op(SDBG_OP_ABORT, 16'h0000, 5'h01, 1'b0, 1'b1);
        check(16'(lows[0]), 16'h0208);
        t_tx(16'h003E, 5'h08);
        $display("t_abort done");
    endtask

    // ============================================================
    // main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        check({13'h0, req_ready, rsp_valid, wire_oe}, 16'h0004);
        check(16'(mode_sel), 16'h0001);
        t_tx(16'h00A5, 5'h08);
        t_tx(16'h96C3, 5'h10);
        t_tx(16'h0001, 5'h01);
        t_rx(16'hB4E1, 1'b1);
        t_rx(16'h5A3C, 1'b0);
        t_ack();
        t_abort();
        results();
    end
endmodule // sdbg_host_tb
`default_nettype wire
